/* hdl/mmss_pkg.sv */
// constants shared by the processor-side address decoder and i/o ports
package mmss_pkg;
    // bus and address layout
    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;
    localparam int BE_W = 4;
    localparam int MEM_SPACE_BIT = 31;
    localparam logic [31:0] MEM_BASE = 32'h8000_0000;
    // dram decode widths
    localparam int DRAM_AW = 22;
    localparam int DRAM_LINES_1MB = 20;
    localparam int DRAM_LINES_2MB = 22;
    localparam int TWO_MB_GAP_BIT = 21;
    localparam int MEM_MBYTES_DEF = 4;
    localparam int ONCHIP_BYTES_DEF = 4096;
    // i/o space word offsets
    localparam logic [4:0] OFF_SUBSYS_RESET_AND_ERROR = 5'h00;
    localparam logic [4:0] OFF_SUBSYS_ANALYSE_CONTROL = 5'h04;
    localparam logic [4:0] OFF_LED_LINE_2 = 5'h08;
    localparam logic [4:0] OFF_LED_LINE_3 = 5'h0c;
    localparam logic [4:0] OFF_LED_LINE_4 = 5'h10;
    localparam logic [4:0] OFF_LED_LINE_5 = 5'h14;
    localparam logic [4:0] OFF_LED_LINE_6 = 5'h18;
    localparam logic [4:0] OFF_LED_LINE_7 = 5'h1c;
    // field positions
    localparam int LED_IDX_LSB = 2;
    localparam int LED_IDX_MSB = 4;
    localparam int ERR_SLOT_LSB = 0;
    localparam int ERR_SLOT_MSB = 2;
    localparam int LED_LANE = 0;
    localparam int PIO_LANE = 3;
    localparam int LED_BIT = 0;
    localparam int ERR_BIT = 0;
    localparam int LED_RESET_LINE = 0;
    localparam int LED_ANALYSE_LINE = 1;
    localparam int N_LEDS = 8;
    // reset values
    localparam logic [7:0] LED_RESET = 8'h00;
    localparam logic [7:0] PIO_RESET = 8'h00;
    localparam logic ERR_IDLE_N = 1'b1;
endpackage

/* hdl/mmss_sync.sv */
// two-stage synchroniser for the asynchronous error pin
`timescale 1ns/10ps
module mmss_sync #(
    parameter logic RESET_VAL = 1'b1
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic din,
    output logic dout
);
    logic meta;

    // first stage feeds only the second
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            meta <= RESET_VAL;
            dout <= RESET_VAL;
        end else begin
            meta <= din;
            dout <= meta;
        end
    end
endmodule

/* hdl/mmss_addr_dec.sv */
// combinational split of the flat address space into dram and i/o
`timescale 1ns/10ps
module mmss_addr_dec #(
    parameter int MEM_MBYTES = mmss_pkg::MEM_MBYTES_DEF,
    parameter int ONCHIP_BYTES = mmss_pkg::ONCHIP_BYTES_DEF
) (
    input wire logic [mmss_pkg::ADDR_W-1:0] addr,
    output logic is_io,
    output logic is_onchip,
    output logic dram_hit,
    output logic [mmss_pkg::DRAM_AW-1:0] dram_addr,
    output logic [2:0] led_idx,
    output logic err_slot
);
    import mmss_pkg::*;

    localparam logic [ADDR_W-1:0] ONCHIP_TOP = MEM_BASE + ADDR_W'(ONCHIP_BYTES);

    // memory space has the top bit set; addresses count up from the most negative
    always_comb begin
        is_io = !addr[MEM_SPACE_BIT];
        is_onchip = addr[MEM_SPACE_BIT] && (addr < ONCHIP_TOP);
        dram_hit = addr[MEM_SPACE_BIT] && !is_onchip;
        if (MEM_MBYTES == 2 && addr[TWO_MB_GAP_BIT]) begin
            dram_hit = 1'b0;
        end
        if (MEM_MBYTES == 1) begin
            dram_addr = {2'b00, addr[DRAM_LINES_1MB-1:0]};
        end else begin
            dram_addr = addr[DRAM_LINES_2MB-1:0];
        end
        led_idx = addr[LED_IDX_MSB:LED_IDX_LSB];
        err_slot = (addr[ERR_SLOT_MSB:ERR_SLOT_LSB] == 3'h0);
    end
endmodule

/* hdl/mmss_decode.sv */
// processor-side memory decode, subsystem services and led port
// Function
// - accesses to on-chip memory region suppress the external dram select.
// - dram uses 20 address lines for 1 MB, 22 for 2 or 4 MB.
// - with 2 MB fitted, alternate 2 MB windows select no memory.
// - programmed i/o answers at every i/o address 3 mod 4.
// - subsystem error is readable at every i/o address multiple of eight.
// - writing 1 at location 0 asserts subsystem reset, 0 deasserts.
// - writing 1 at location 4 asserts analyse; reads there are undefined.
// - reading location 0 gives error state in bit 0, 1 when asserted.
// - subsystem reset, analyse and error pins are active low.
// - services and leds use the low lane, programmed i/o the high lane.
// - led line n written at 4n; bit 0 sets level, 1 is high.
// - led lines are low at power-on and survive a processor reset.
// - reset and analyse outputs are inverted led lines 0 and 1.
// - power transistors follow analyse; 0 on led line 1 powers on.
// - each led bit aliases at 32i plus 4n across i/o space.
`timescale 1ns/10ps
module mmss_decode #(
    parameter int MEM_MBYTES = mmss_pkg::MEM_MBYTES_DEF,
    parameter int ONCHIP_BYTES = mmss_pkg::ONCHIP_BYTES_DEF
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic cpu_reset_n,
    input wire logic bus_req,
    input wire logic bus_we,
    input wire logic [mmss_pkg::ADDR_W-1:0] bus_addr,
    input wire logic [mmss_pkg::BE_W-1:0] bus_be,
    input wire logic [mmss_pkg::DATA_W-1:0] bus_wdata,
    output logic bus_ack,
    output logic [mmss_pkg::DATA_W-1:0] bus_rdata,
    output logic dram_sel,
    output logic [mmss_pkg::DRAM_AW-1:0] dram_addr,
    input wire logic subsys_error_n,
    output logic subsys_reset_n,
    output logic subsys_analyse_n,
    output logic power_on,
    output logic [mmss_pkg::N_LEDS-1:0] led_lines,
    output logic [7:0] pio_lines
);
    import mmss_pkg::*;

    typedef struct packed {
        logic [N_LEDS-1:0] led;
        logic [7:0] pio;
        logic ack;
        logic [DATA_W-1:0] rdata;
        logic dram_sel;
        logic [DRAM_AW-1:0] dram_addr;
    } mmss_state_t;

    mmss_state_t st;
    mmss_state_t next_st;
    logic dec_is_io;
    logic dec_onchip;
    logic dec_dram_hit;
    logic [DRAM_AW-1:0] dec_dram_addr;
    logic [2:0] dec_led_idx;
    logic dec_err_slot;
    logic err_n_sync;
    logic io_req;

    // true when byte lane n is enabled in this access
    function automatic logic lane_on(input logic [BE_W-1:0] be, input int lane);
        lane_on = be[lane];
    endfunction

    // address split into memory and i/o views
    mmss_addr_dec #(
        .MEM_MBYTES(MEM_MBYTES),
        .ONCHIP_BYTES(ONCHIP_BYTES)
    ) u_dec (
        .addr(bus_addr),
        .is_io(dec_is_io),
        .is_onchip(dec_onchip),
        .dram_hit(dec_dram_hit),
        .dram_addr(dec_dram_addr),
        .led_idx(dec_led_idx),
        .err_slot(dec_err_slot)
    );

    // error pin is asynchronous to the processor clock
    mmss_sync #(
        .RESET_VAL(ERR_IDLE_N)
    ) u_err_sync (
        .clk(clk),
        .resetn(resetn),
        .din(subsys_error_n),
        .dout(err_n_sync)
    );

    // requests are ignored while the processor is held in reset
    assign io_req = bus_req && cpu_reset_n && dec_is_io;

    // next-state logic for bus answers, dram select and port latches
    always_comb begin
        next_st = st;
        next_st.ack = 1'b0;
        next_st.dram_sel = 1'b0;
        if (!cpu_reset_n) begin
            // processor reset clears bus answers only; latches are kept
            next_st.rdata = '0;
            next_st.dram_addr = '0;
        end else if (bus_req && !dec_is_io) begin
            next_st.dram_sel = dec_dram_hit;
            next_st.dram_addr = dec_dram_addr;
        end else if (io_req) begin
            next_st.ack = 1'b1;
            if (bus_we) begin
                // low lane steers the led lines, aliased every 32 bytes
                if (lane_on(bus_be, LED_LANE)) begin
                    next_st.led[dec_led_idx] = bus_wdata[LED_BIT];
                end
                // high lane steers the programmed i/o lines
                if (lane_on(bus_be, PIO_LANE)) begin
                    next_st.pio = bus_wdata[8*PIO_LANE +: 8];
                end
            end else begin
                next_st.rdata = '0;
                // error bit reads 1 when the pin is low
                if (lane_on(bus_be, LED_LANE) && dec_err_slot) begin
                    next_st.rdata[ERR_BIT] = !err_n_sync;
                end
                if (lane_on(bus_be, PIO_LANE)) begin
                    next_st.rdata[8*PIO_LANE +: 8] = st.pio;
                end
            end
        end
    end

    // power-on reset is the only thing that clears the latches
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st.led <= LED_RESET;
            st.pio <= PIO_RESET;
            st.ack <= 1'b0;
            st.rdata <= '0;
            st.dram_sel <= 1'b0;
            st.dram_addr <= '0;
        end else begin
            st <= next_st;
        end
    end

    // outputs straight from the state; services pins are inverted led lines
    assign bus_ack = st.ack;
    assign bus_rdata = st.rdata;
    assign dram_sel = st.dram_sel;
    assign dram_addr = st.dram_addr;
    assign led_lines = st.led;
    assign pio_lines = st.pio;
    assign subsys_reset_n = !st.led[LED_RESET_LINE];
    assign subsys_analyse_n = !st.led[LED_ANALYSE_LINE];
    assign power_on = !st.led[LED_ANALYSE_LINE];

    // on-chip region never selects external dram
    a_onchip_blocks_dram: assert property (@(posedge clk) disable iff (!resetn)
        bus_req && cpu_reset_n && !dec_is_io && dec_onchip |=> !dram_sel)
        else $error("dram selected inside on-chip region");

    // dram address keeps only the fitted address lines
    a_dram_alias: assert property (@(posedge clk) disable iff (!resetn)
        bus_req && cpu_reset_n && dec_dram_hit |=> dram_sel &&
        dram_addr == ((MEM_MBYTES == 1) ? {2'b00, $past(bus_addr[DRAM_LINES_1MB-1:0])}
                                        : $past(bus_addr[DRAM_LINES_2MB-1:0])))
        else $error("dram address or select wrong");

    // odd 2 MB windows select nothing on a 2 MB board
    a_two_mb_gap: assert property (@(posedge clk) disable iff (!resetn)
        (MEM_MBYTES == 2) && bus_req && bus_addr[MEM_SPACE_BIT] && bus_addr[TWO_MB_GAP_BIT]
        |=> !dram_sel)
        else $error("dram selected in 2 MB gap");

    // high lane write lands on programmed i/o lines and is acknowledged
    a_pio_write: assert property (@(posedge clk) disable iff (!resetn)
        io_req && bus_we && bus_be[PIO_LANE] |=> bus_ack && pio_lines == $past(bus_wdata[31:24]))
        else $error("programmed i/o write lost");

    // error bit reads inverted synchronised pin at 8n
    a_err_read: assert property (@(posedge clk) disable iff (!resetn)
        io_req && !bus_we && bus_be[LED_LANE] && dec_err_slot
        |=> bus_ack && bus_rdata[ERR_BIT] == !$past(err_n_sync))
        else $error("error bit read wrong");

    // writing 1 at location 0 pulls the reset pin low, 0 releases it
    a_reset_write: assert property (@(posedge clk) disable iff (!resetn)
        io_req && bus_we && bus_be[LED_LANE] && bus_addr[4:0] == OFF_SUBSYS_RESET_AND_ERROR
        |=> subsys_reset_n == !$past(bus_wdata[LED_BIT]))
        else $error("subsystem reset not following write");

    // analyse and power follow a write at location 4
    a_analyse_power: assert property (@(posedge clk) disable iff (!resetn)
        io_req && bus_we && bus_be[LED_LANE] && bus_addr[4:0] == OFF_SUBSYS_ANALYSE_CONTROL
        |=> subsys_analyse_n == !$past(bus_wdata[LED_BIT]) && power_on == subsys_analyse_n)
        else $error("analyse or power not following write");

    // any aliased led address writes line n
    a_led_alias: assert property (@(posedge clk) disable iff (!resetn)
        io_req && bus_we && bus_be[LED_LANE]
        |=> led_lines[$past(bus_addr[4:2])] == $past(bus_wdata[LED_BIT]))
        else $error("led line not written at alias");

    // processor reset leaves the latches alone
    a_led_hold: assert property (@(posedge clk) disable iff (!resetn)
        !cpu_reset_n |=> $stable(led_lines) && $stable(pio_lines))
        else $error("latch changed during processor reset");

    // a write without the low lane never touches the leds
    a_lane_isolate: assert property (@(posedge clk) disable iff (!resetn)
        bus_req && bus_we && !bus_be[LED_LANE] |=> $stable(led_lines))
        else $error("led changed by high lane write");

    // no answer without an accepted i/o request
    a_idle_no_ack: assert property (@(posedge clk) disable iff (!resetn)
        !io_req
        |=> !bus_ack)
        else $error("acknowledge without i/o request");

    // every accepted i/o request is answered next cycle
    a_io_ack: assert property (@(posedge clk) disable iff (!resetn)
        io_req
        |=> bus_ack)
        else $error("i/o request not acknowledged");

    // memory space accesses never acknowledge on the i/o path
    a_mem_no_ack: assert property (@(posedge clk) disable iff (!resetn)
        bus_req && !dec_is_io
        |=> !bus_ack)
        else $error("memory access acknowledged as i/o");

    // dram select only follows a decoded dram hit
    a_sel_needs_hit: assert property (@(posedge clk) disable iff (!resetn)
        !(bus_req && cpu_reset_n && dec_dram_hit)
        |=> !dram_sel)
        else $error("dram selected without a hit");

    // even 2 MB windows outside on-chip memory do hit dram
    a_gap_even_hits: assert property (@(posedge clk) disable iff (!resetn)
        (MEM_MBYTES == 2) && bus_req && cpu_reset_n && bus_addr[MEM_SPACE_BIT] && !bus_addr[TWO_MB_GAP_BIT] && !dec_onchip
        |=> dram_sel)
        else $error("populated 2 MB window missed");

    // dram address only moves on a memory access or a processor reset
    a_dram_addr_hold: assert property (@(posedge clk) disable iff (!resetn)
        cpu_reset_n && !(bus_req && !dec_is_io)
        |=> $stable(dram_addr))
        else $error("dram address moved without memory access");

    // processor reset quiets the bus answers
    a_cpu_reset_quiet: assert property (@(posedge clk) disable iff (!resetn)
        !cpu_reset_n
        |=> !bus_ack && !dram_sel && bus_rdata == '0 && dram_addr == '0)
        else $error("bus answer during processor reset");

    // programmed i/o lines move only on a high lane write
    a_pio_write_only: assert property (@(posedge clk) disable iff (!resetn)
        !(io_req && bus_we && bus_be[PIO_LANE])
        |=> $stable(pio_lines))
        else $error("programmed i/o changed without write");

    // led lines move only on a low lane write
    a_led_write_only: assert property (@(posedge clk) disable iff (!resetn)
        !(io_req && bus_we && bus_be[LED_LANE])
        |=> $stable(led_lines))
        else $error("led changed without write");

    // a write reaches only the addressed led line
    a_led_others_kept: assert property (@(posedge clk) disable iff (!resetn)
        io_req && bus_we
        |=> (led_lines & ~(8'h01 << $past(bus_addr[4:2]))) == ($past(led_lines) & ~(8'h01 << $past(bus_addr[4:2]))))
        else $error("write disturbed another led line");

    // word write updates both lanes at once
    a_word_both: assert property (@(posedge clk) disable iff (!resetn)
        io_req && bus_we && bus_be == 4'hf
        |=> pio_lines == $past(bus_wdata[31:24]) && led_lines[$past(bus_addr[4:2])] == $past(bus_wdata[LED_BIT]))
        else $error("word write missed a lane");

    // high lane read returns the programmed i/o lines
    a_pio_read: assert property (@(posedge clk) disable iff (!resetn)
        io_req && !bus_we && bus_be[PIO_LANE]
        |=> bus_rdata[31:24] == $past(pio_lines))
        else $error("programmed i/o read wrong");

    // bits outside error and programmed i/o read as zero
    a_rdata_unused: assert property (@(posedge clk) disable iff (!resetn)
        io_req && !bus_we
        |=> bus_rdata[23:1] == 23'h0)
        else $error("unused read bits not zero");

    // read data holds until the next i/o read or a processor reset
    a_rdata_hold: assert property (@(posedge clk) disable iff (!resetn)
        cpu_reset_n && !(io_req && !bus_we)
        |=> $stable(bus_rdata))
        else $error("read data moved without read");

    // error bit is zero away from the 8n slots
    a_err_slot_only: assert property (@(posedge clk) disable iff (!resetn)
        io_req && !bus_we && bus_addr[ERR_SLOT_MSB:ERR_SLOT_LSB] != 3'h0
        |=> !bus_rdata[ERR_BIT])
        else $error("error bit outside its slot");

    // analyse location reads back no service state
    a_loc4_read: assert property (@(posedge clk) disable iff (!resetn)
        io_req && !bus_we && bus_addr[4:0] == OFF_SUBSYS_ANALYSE_CONTROL
        |=> bus_rdata[7:0] == 8'h00)
        else $error("analyse location read not zero");

    // a low error pin reads as a set error bit
    a_err_low_active: assert property (@(posedge clk) disable iff (!resetn)
        io_req && !bus_we && bus_be[LED_LANE] && dec_err_slot && !err_n_sync
        |=> bus_rdata[ERR_BIT])
        else $error("low error pin not reported");

    // error pin reaches reads two cycles late
    a_err_sync_lag: assert property (@(posedge clk) disable iff (!resetn)
        $past(resetn) && $past(resetn, 2)
        |-> err_n_sync == $past(subsys_error_n, 2))
        else $error("error synchroniser lag wrong");

    // a write to led line 2 leaves the service pins alone
    a_services_kept: assert property (@(posedge clk) disable iff (!resetn)
        io_req && bus_we && bus_addr[4:0] == OFF_LED_LINE_2
        |=> $stable(subsys_reset_n) && $stable(subsys_analyse_n))
        else $error("service pin moved by led line 2");

    // any alias of led line 1 switches power inversely
    a_power_write: assert property (@(posedge clk) disable iff (!resetn)
        io_req && bus_we && bus_be[LED_LANE] && bus_addr[4:2] == 3'h1
        |=> power_on == !$past(bus_wdata[LED_BIT]))
        else $error("power not following led line 1");
endmodule

/* testbench/mmss_cpu_model.sv */
// processor bus master model issuing single byte and word accesses
`timescale 1ns/10ps
module mmss_cpu_model (
    input wire logic clk,
    output logic bus_req,
    output logic bus_we,
    output logic [mmss_pkg::ADDR_W-1:0] bus_addr,
    output logic [mmss_pkg::BE_W-1:0] bus_be,
    output logic [mmss_pkg::DATA_W-1:0] bus_wdata,
    input wire logic bus_ack,
    input wire logic [mmss_pkg::DATA_W-1:0] bus_rdata,
    input wire logic dram_sel
);
    import mmss_pkg::*;
    // idle bus at time zero
    initial begin
        bus_req = 1'b0;
        bus_we = 1'b0;
        bus_addr = 32'h0;
        bus_be = 4'h0;
        bus_wdata = 32'h0;
    end
    // one-cycle request; released lines flip so stale values never look valid
    task automatic access(input logic we, input logic [31:0] a, input logic [3:0] be, input logic [31:0] d,
            output logic ack, output logic [31:0] rd, output logic sel);
        @(posedge clk);
        bus_req <= 1'b1;
        bus_we <= we;
        bus_addr <= a;
        bus_be <= be;
        bus_wdata <= d;
        @(posedge clk);
        bus_req <= 1'b0;
        bus_addr <= ~a;
        bus_be <= ~be;
        bus_wdata <= ~d;
        #1;
        ack = bus_ack;
        rd = bus_rdata;
        sel = dram_sel;
    endtask
endmodule

/* testbench/test_mmio_subsystem_led_decode.sv */
// self-checking bench for the processor-side decoder and led port
`timescale 1ns/10ps
module test_mmio_subsystem_led_decode;
    import mmss_pkg::*;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic cpu_reset_n = 1'b1;
    logic subsys_error_n = 1'b1;
    logic bus_req, bus_we, bus_ack, dram_sel, subsys_reset_n, subsys_analyse_n, power_on, ack, sel;
    logic [ADDR_W-1:0] bus_addr;
    logic [BE_W-1:0] bus_be;
    logic [DATA_W-1:0] bus_wdata, bus_rdata, rd;
    logic [DRAM_AW-1:0] dram_addr;
    logic dram_sel_mb1;
    logic [DRAM_AW-1:0] dram_addr_mb1;
    logic [N_LEDS-1:0] led_lines;
    logic [7:0] pio_lines;
    int failures = 0;
    int n_tests = 0;
    int led_m[8];
    int pio_m;
    int err_m;
    // 200 MHz clock
    always #2.5 clk = ~clk;
    mmss_decode #(.MEM_MBYTES(2)) mmss_decode_inst (.clk(clk), .resetn(resetn), .cpu_reset_n(cpu_reset_n),
        .bus_req(bus_req), .bus_we(bus_we), .bus_addr(bus_addr), .bus_be(bus_be), .bus_wdata(bus_wdata),
        .bus_ack(bus_ack), .bus_rdata(bus_rdata), .dram_sel(dram_sel), .dram_addr(dram_addr),
        .subsys_error_n(subsys_error_n), .subsys_reset_n(subsys_reset_n), .subsys_analyse_n(subsys_analyse_n),
        .power_on(power_on), .led_lines(led_lines), .pio_lines(pio_lines));
    mmss_cpu_model mmss_cpu_model_inst (.clk(clk), .bus_req(bus_req), .bus_we(bus_we), .bus_addr(bus_addr),
        .bus_be(bus_be), .bus_wdata(bus_wdata), .bus_ack(bus_ack), .bus_rdata(bus_rdata), .dram_sel(dram_sel));
    // a 1 MB board on the same bus, for the narrower dram decode
    mmss_decode #(.MEM_MBYTES(1)) mmss_decode_mb1_inst (.clk(clk), .resetn(resetn), .cpu_reset_n(cpu_reset_n),
        .bus_req(bus_req), .bus_we(bus_we), .bus_addr(bus_addr), .bus_be(bus_be), .bus_wdata(bus_wdata),
        .bus_ack(), .bus_rdata(), .dram_sel(dram_sel_mb1), .dram_addr(dram_addr_mb1),
        .subsys_error_n(subsys_error_n), .subsys_reset_n(), .subsys_analyse_n(), .power_on(), .led_lines(),
        .pio_lines());
    // compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // model pins against design pins
    task automatic chk_pins();
        logic [7:0] v;
        for (int k = 0; k < 8; k++) v[k] = led_m[k][0];
        chk(led_lines, v);
        chk(pio_lines, pio_m[7:0]);
        chk(subsys_reset_n, !led_m[0][0]);
        chk(subsys_analyse_n, !led_m[1][0]);
        chk(power_on, !led_m[1][0]);
    endtask
    // write, update model, check
    task automatic wr(input logic [31:0] a, input logic [3:0] be, input logic [31:0] d);
        mmss_cpu_model_inst.access(1'b1, a, be, d, ack, rd, sel);
        if (be[0]) led_m[a[4:2]] = d[0];
        if (be[3]) pio_m = d[31:24];
        chk(ack, 1);
        chk_pins();
    endtask
    // read with model expectation
    task automatic rdchk(input logic [31:0] a, input logic [3:0] be);
        logic [31:0] e;
        e = 32'h0;
        if (be[3]) e[31:24] = pio_m[7:0];
        if (be[0] && a[2:0] == 3'h0) e[0] = err_m[0];
        mmss_cpu_model_inst.access(1'b0, a, be, 32'h0, ack, rd, sel);
        chk(ack, 1);
        chk(rd, e);
    endtask
    // memory space access
    task automatic mem(input logic [31:0] a, input logic hit, input logic hit1);
        mmss_cpu_model_inst.access(1'b0, a, 4'hf, 32'h0, ack, rd, sel);
        chk(sel, hit);
        chk(ack, 0);
        if (hit) chk(dram_addr, a[21:0]);
        chk(dram_sel_mb1, hit1);
        if (hit1) chk(dram_addr_mb1, {2'b00, a[19:0]});
    endtask
    // counts and verdict
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // watchdog
    initial begin
        #100000;
        failures++;
        stop_test();
    end
    // main sequence
    initial begin
        void'($urandom(32'h5323));
        for (int k = 0; k < 8; k++) led_m[k] = 0;
        pio_m = 0;
        err_m = 0;
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        @(negedge clk);
        chk_pins();
        for (int k = 0; k < 24; k++) wr(($urandom() & 32'h7fff_ffe0) | (k % 8) * 4, 4'h1, $urandom());
        wr(($urandom() & 32'h7fff_fffc) | 3, 4'h8, $urandom());
        wr(32'h4, 4'hf, 32'h5a00_0000);
        wr(32'h0, 4'hf, 32'ha500_0001);
        wr(32'h4, 4'h1, 32'h1);
        rdchk(32'h3, 4'h8);
        // error pin through the synchroniser, both levels
        for (int k = 0; k < 2; k++) begin
            @(posedge clk) subsys_error_n <= k[0];
            err_m = 1 - k;
            repeat (3) @(posedge clk);
            rdchk($urandom() & 32'h7fff_fff8, 4'hf);
        end
        rdchk(32'h4, 4'h1);
        // processor reset keeps leds and ignores requests
        @(posedge clk) cpu_reset_n <= 1'b0;
        mmss_cpu_model_inst.access(1'b1, 32'h0, 4'h9, 32'h0, ack, rd, sel);
        chk(ack, 0);
        chk_pins();
        @(posedge clk) cpu_reset_n <= 1'b1;
        mem(32'h8000_0100, 1'b0, 1'b0);
        mem(32'h8040_8000, 1'b1, 1'b1);
        mem(32'h8020_8000, 1'b0, 1'b1);
        mem(32'h80c0_8000, 1'b1, 1'b1);
        mem(32'h8010_8000, 1'b1, 1'b1);
        // power-on reset clears leds and pio
        @(posedge clk) resetn <= 1'b0;
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        for (int k = 0; k < 8; k++) led_m[k] = 0;
        pio_m = 0;
        @(negedge clk);
        chk_pins();
        stop_test();
    end
endmodule
